/* File: rtl/bbs_pkg.sv */
`default_nettype none

package bbs_pkg;

	// ***************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ***************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00; // Bit 0: extended set enable
	localparam logic [7:0] REG_BANK   = 8'h04; // Bank select, bits 3:0
	localparam logic [7:0] REG_INDEX  = 8'h08; // Indexed-offset base, bits 11:0
	localparam logic [7:0] REG_FLAGS  = 8'h0C; // Status flags N, OV, Z
	localparam logic [7:0] REG_PC     = 8'h10; // Program counter
	localparam logic [7:0] REG_INSTR  = 8'h14; // Write issues one instruction
	localparam logic [7:0] REG_STATUS = 8'h18; // Busy, bad opcode (write 1 clears)

	// ***************************************************************
	// Field positions and reset values
	// ***************************************************************
	localparam int CTRL_EXT   = 0;
	localparam int FLG_Z      = 0;
	localparam int FLG_OV     = 1;
	localparam int FLG_N      = 2;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_BAD   = 1;
	localparam int PC_W       = 21;
	localparam int ADDR_W     = 12;
	localparam logic [PC_W-1:0]   PC_RESET    = 21'h00_0000;
	localparam logic [PC_W-1:0]   PC_INC      = 21'h00_0002;
	localparam logic [ADDR_W-1:0] INDEX_RESET = 12'h000;

	// ***************************************************************
	// Opcodes, addressing and timing
	// ***************************************************************
	localparam logic [7:0] OP_BR_NOT_NEG = 8'hE7;
	localparam logic [7:0] OP_BR_NOT_OV  = 8'hE5;
	localparam logic [7:0] OP_BR_NOT_Z   = 8'hE1;
	localparam logic [4:0] OP_BR_ALWAYS  = 5'h1A;  // 1101 0
	localparam logic [3:0] OP_SET_BIT    = 4'h8;
	localparam logic [7:0] IDX_LIMIT      = 8'h5F; // 95
	localparam logic [7:0] ACCESS_SPLIT   = 8'h80; // Low half of access bank
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;  // Bank of the upper half
	localparam int         QPHASES        = 4;     // Quarter-cycles per cycle

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} bbs_state_t;
	typedef enum logic [2:0] {
		K_BRANCH_NOT_NEGATIVE, K_BRANCH_NOT_OVERFLOW, K_BRANCH_NOT_ZERO,
		K_BRANCH_ALWAYS, K_SET_FILE_BIT, K_BAD
	} bbs_kind_t;

endpackage : bbs_pkg

`default_nettype wire

/* File: rtl/bbs_q_if.sv */
`timescale 1ns/1ns
`default_nettype none

// Quarter-cycle phase shared between the sequencer and the core
interface bbs_q_if;
	logic       run;
	logic [1:0] q;
	modport seq  (input run, output q);
	modport core (output run, input q);
endinterface : bbs_q_if

`default_nettype wire

/* File: rtl/bbs_qseq.sv */
`timescale 1ns/1ns
`default_nettype none

module bbs_qseq (
	input  wire logic clk_i,
	input  wire logic rst_i,
	bbs_q_if.seq      qb
);
	// ***************************************************************
	// Quarter-cycle counter
	// ***************************************************************
	typedef struct packed {
		logic [1:0] q;
	} bbs_seq_t;

	bbs_seq_t s_q;
	bbs_seq_t s_d;

	// The phase counter is two bits wide, so only four phases fit
	if (bbs_pkg::QPHASES != 4) begin : g_chk
		$error("bbs_qseq: phase count must be four");
	end

	// Held at Q1 while idle so every instruction starts on a clean Q1
	always_comb begin
		s_d = s_q;
		s_d.q = qb.run ? s_q.q + 2'd1 : 2'd0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign qb.q = s_q.q;

endmodule : bbs_qseq

`default_nettype wire

/* File: rtl/bbs_core.sv */
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module bbs_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [11:0] mem_addr_o,
	output logic      [7:0]  mem_wdata_o,
	output logic             mem_we_o,
	input  wire logic [7:0]  mem_rdata_i,
	output logic      [20:0] pc_o,
	output logic             busy_o
);
	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		bbs_pkg::bbs_state_t state;
		bbs_pkg::bbs_kind_t  kind;
		logic [15:0] ir;
		logic [20:0] pc;
		logic [20:0] target;
		logic [10:0] off;
		logic        taken;
		logic [11:0] maddr;
		logic [7:0]  mwdata;
		logic        mwe;
		logic [7:0]  rdat;
		logic        ext_en;
		logic [3:0]  bank;
		logic [11:0] index;
		logic [2:0]  flags;
		logic        bad;
		logic        busy;
		logic        ack;
		logic [31:0] dato;
	} bbs_core_t;

	bbs_core_t   s_q;
	bbs_core_t   s_d;
	bbs_q_if     qb ();
	logic        req;
	logic [7:0]  bmask;
	logic [11:0] idx_addr;

	bbs_qseq u_qseq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.qb    (qb.seq)
	);

	assign qb.run   = s_q.busy;
	assign req      = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign bmask    = 8'h01 << s_q.ir[11:9];
	assign idx_addr = s_q.index + {4'h0, s_q.ir[7:0]};

	// Only the lanes enabled by sel are written
	function automatic logic [31:0] lane_merge(input logic [31:0] o, input logic [31:0] w,
		input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = w[i*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// ***************************************************************
	// Bus slave and instruction execution
	// ***************************************************************
	always_comb begin
		logic [31:0] wv;
		wv = 32'h0000_0000;
		s_d = s_q;
		s_d.mwe = 1'b0;
		s_d.ack = 1'b0;
		// One wait state: ack the cycle after the request, drop it the next
		if (req) begin
			s_d.ack = 1'b1;
			case (wb_adr_i)
				bbs_pkg::REG_CTRL:   s_d.dato = {31'h0000_0000, s_q.ext_en};
				bbs_pkg::REG_BANK:   s_d.dato = {28'h000_0000, s_q.bank};
				bbs_pkg::REG_INDEX:  s_d.dato = {20'h0_0000, s_q.index};
				bbs_pkg::REG_FLAGS:  s_d.dato = {29'h0000_0000, s_q.flags};
				bbs_pkg::REG_PC:     s_d.dato = {11'h000, s_q.pc};
				bbs_pkg::REG_INSTR:  s_d.dato = {16'h0000, s_q.ir};
				bbs_pkg::REG_STATUS: s_d.dato = {30'h0000_0000, s_q.bad, s_q.busy};
				default:             s_d.dato = 32'h0000_0000;
			endcase
			if (wb_we_i) begin
				case (wb_adr_i)
					bbs_pkg::REG_CTRL: begin
						wv = lane_merge({31'h0000_0000, s_q.ext_en}, wb_dat_i, wb_sel_i);
						s_d.ext_en = wv[bbs_pkg::CTRL_EXT];
					end
					bbs_pkg::REG_BANK: begin
						wv = lane_merge({28'h000_0000, s_q.bank}, wb_dat_i, wb_sel_i);
						s_d.bank = wv[3:0];
					end
					bbs_pkg::REG_INDEX: begin
						wv = lane_merge({20'h0_0000, s_q.index}, wb_dat_i, wb_sel_i);
						s_d.index = wv[11:0];
					end
					bbs_pkg::REG_FLAGS: begin
						wv = lane_merge({29'h0000_0000, s_q.flags}, wb_dat_i, wb_sel_i);
						s_d.flags = wv[2:0];
					end
					bbs_pkg::REG_PC: begin
						// PC moves under software only between instructions
						wv = lane_merge({11'h000, s_q.pc}, wb_dat_i, wb_sel_i);
						if (!s_q.busy) begin
							s_d.pc = wv[20:0];
						end
					end
					bbs_pkg::REG_INSTR: begin
						wv = lane_merge({16'h0000, s_q.ir}, wb_dat_i, wb_sel_i);
						if (!s_q.busy) begin
							s_d.ir    = wv[15:0];
							s_d.state = bbs_pkg::ST_EXEC;
							s_d.busy  = 1'b1;
						end
					end
					bbs_pkg::REG_STATUS: begin
						if (wb_sel_i[0] && wb_dat_i[bbs_pkg::STAT_BAD]) begin
							s_d.bad = 1'b0;
						end
					end
					default: ;
				endcase
			end
		end
		// Execution follows the bus so a hardware set beats a software clear
		case (s_q.state)
			bbs_pkg::ST_EXEC: begin
				case (qb.q)
					2'd0: begin
						// Q1: decode, step PC past this word, form file address
						s_d.pc = s_q.pc + bbs_pkg::PC_INC;
						if (s_q.ir[15:8] == bbs_pkg::OP_BR_NOT_NEG) begin
							s_d.kind = bbs_pkg::K_BRANCH_NOT_NEGATIVE;
						end else if (s_q.ir[15:8] == bbs_pkg::OP_BR_NOT_OV) begin
							s_d.kind = bbs_pkg::K_BRANCH_NOT_OVERFLOW;
						end else if (s_q.ir[15:8] == bbs_pkg::OP_BR_NOT_Z) begin
							s_d.kind = bbs_pkg::K_BRANCH_NOT_ZERO;
						end else if (s_q.ir[15:11] == bbs_pkg::OP_BR_ALWAYS) begin
							s_d.kind = bbs_pkg::K_BRANCH_ALWAYS;
						end else if (s_q.ir[15:12] == bbs_pkg::OP_SET_BIT) begin
							s_d.kind = bbs_pkg::K_SET_FILE_BIT;
						end else begin
							s_d.kind = bbs_pkg::K_BAD;
						end
						if (!s_q.ir[8] && s_q.ext_en && s_q.ir[7:0] <= bbs_pkg::IDX_LIMIT) begin
							s_d.maddr = idx_addr;
						end else if (s_q.ir[8]) begin
							s_d.maddr = {s_q.bank, s_q.ir[7:0]};
						end else if (s_q.ir[7:0] < bbs_pkg::ACCESS_SPLIT) begin
							s_d.maddr = {4'h0, s_q.ir[7:0]};
						end else begin
							s_d.maddr = {bbs_pkg::ACCESS_HI_BANK, s_q.ir[7:0]};
						end
					end
					2'd1: begin
						// Q2: read the literal; the memory sees the address now
						if (s_q.kind == bbs_pkg::K_BRANCH_ALWAYS) begin
							s_d.off = s_q.ir[10:0];
						end else begin
							s_d.off = {{3{s_q.ir[7]}}, s_q.ir[7:0]};
						end
					end
					2'd2: begin
						// Q3: process; flags are sampled here, not at decode
						s_d.rdat   = mem_rdata_i;
						s_d.target = s_q.pc + {{9{s_q.off[10]}}, s_q.off, 1'b0};
						case (s_q.kind)
							bbs_pkg::K_BRANCH_NOT_NEGATIVE: s_d.taken = ~s_q.flags[bbs_pkg::FLG_N];
							bbs_pkg::K_BRANCH_NOT_OVERFLOW: s_d.taken = ~s_q.flags[bbs_pkg::FLG_OV];
							bbs_pkg::K_BRANCH_NOT_ZERO:     s_d.taken = ~s_q.flags[bbs_pkg::FLG_Z];
							bbs_pkg::K_BRANCH_ALWAYS:       s_d.taken = 1'b1;
							default:                        s_d.taken = 1'b0;
						endcase
					end
					default: begin
						// Q4: write PC or file register
						s_d.state = bbs_pkg::ST_IDLE;
						s_d.busy  = 1'b0;
						if (s_q.taken) begin
							s_d.pc    = s_q.target;
							s_d.state = bbs_pkg::ST_NOP;
							s_d.busy  = 1'b1;
						end
						if (s_q.kind == bbs_pkg::K_SET_FILE_BIT) begin
							s_d.mwdata = s_q.rdat | bmask;
							s_d.mwe    = 1'b1;
						end
						if (s_q.kind == bbs_pkg::K_BAD) begin
							s_d.bad = 1'b1;
						end
					end
				endcase
			end
			bbs_pkg::ST_NOP: begin
				// Second cycle of a taken branch: four idle quarters
				if (qb.q == 2'd3) begin
					s_d.state = bbs_pkg::ST_IDLE;
					s_d.busy  = 1'b0;
					s_d.taken = 1'b0;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q       <= '0;
			s_q.state <= bbs_pkg::ST_IDLE;
			s_q.kind  <= bbs_pkg::K_BAD;
			s_q.pc    <= bbs_pkg::PC_RESET;
			s_q.index <= bbs_pkg::INDEX_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign wb_dat_o    = s_q.dato;
	assign wb_ack_o    = s_q.ack;
	assign mem_addr_o  = s_q.maddr;
	assign mem_wdata_o = s_q.mwdata;
	assign mem_we_o    = s_q.mwe;
	assign pc_o        = s_q.pc;
	assign busy_o      = s_q.busy;

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ovf_cond: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && s_q.kind == bbs_pkg::K_BRANCH_NOT_OVERFLOW)
		|-> s_q.taken == ~$past(s_q.flags[bbs_pkg::FLG_OV])) else $error("overflow branch decision wrong");
	chk_zero_cond: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && s_q.kind == bbs_pkg::K_BRANCH_NOT_ZERO)
		|-> s_q.taken == ~$past(s_q.flags[bbs_pkg::FLG_Z])) else $error("zero branch decision wrong");
	chk_neg_cond: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && s_q.kind == bbs_pkg::K_BRANCH_NOT_NEGATIVE)
		|-> s_q.taken == ~$past(s_q.flags[bbs_pkg::FLG_N])) else $error("negative branch decision wrong");
	chk_pc_step: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd0)
		|=> s_q.pc == $past(s_q.pc) + bbs_pkg::PC_INC) else $error("PC not stepped by two");
	chk_pc_target: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && s_q.taken)
		|=> s_q.pc == $past(s_q.target)) else $error("taken branch PC wrong");
	chk_taken_two: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && s_q.taken)
		|=> (s_q.state == bbs_pkg::ST_NOP)[*4] ##1 s_q.state == bbs_pkg::ST_IDLE) else $error("taken not two cycles");
	chk_untaken_one: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && !s_q.taken)
		|=> s_q.state == bbs_pkg::ST_IDLE && !s_q.busy) else $error("untaken not one cycle");
	chk_always_taken: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && s_q.kind == bbs_pkg::K_BRANCH_ALWAYS)
		|-> s_q.taken ##1 s_q.state == bbs_pkg::ST_NOP) else $error("unconditional branch not taken");
	chk_set_bit: assert property (
		s_q.mwe |-> (s_q.mwdata == ($past(mem_rdata_i, 2) | (8'h01 << s_q.ir[11:9])))
		##1 !s_q.mwe) else $error("bit set data wrong");
	chk_bank_addr: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd1 && s_q.ir[8])
		|-> s_q.maddr == {$past(s_q.bank), s_q.ir[7:0]}) else $error("banked address wrong");
	chk_index_addr: assert property (
		(s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd1 && !s_q.ir[8] && $past(s_q.ext_en)
		&& s_q.ir[7:0] <= bbs_pkg::IDX_LIMIT) |-> s_q.maddr == $past(idx_addr)) else $error("indexed address wrong");

	cov_taken:   cover property (s_q.state == bbs_pkg::ST_NOP && qb.q == 2'd3);
	cov_untaken: cover property (s_q.state == bbs_pkg::ST_EXEC && qb.q == 2'd3 && !s_q.taken
		&& s_q.kind == bbs_pkg::K_BRANCH_NOT_ZERO);
	cov_set_bit: cover property (s_q.mwe);
	cov_bad_op:  cover property (s_q.bad);

endmodule : bbs_core

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_we_o, busy_o;
	logic [7:0]  wb_adr_i, mem_wdata_o, mem_rdata_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, r;
	logic [11:0] mem_addr_o;
	logic [20:0] pc_o;
	logic [7:0]  ram [0:4095];
	logic [7:0]  off;
	logic [10:0] off11;
	int          miscompares, check_count, cycles, writes, pc_m, fl, bank_m, index_m, addr, w0;
	int          seed = 51726;
	logic [7:0]  ops [3] = '{8'hE7, 8'hE5, 8'hE1};
	int          fbit [3] = '{2, 1, 0};
	int          fa [8] = '{8'h10, 8'h90, 8'h3C, 8'h5F, 8'h60, 8'h20, 8'h00, 8'hFF};
	int          av [8] = '{0, 0, 1, 0, 0, 1, 0, 0};
	int          ex [8] = '{0, 0, 0, 1, 1, 1, 1, 1};

	bbs_core bbs_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_we_o(mem_we_o), .mem_rdata_i(mem_rdata_i), .pc_o(pc_o), .busy_o(busy_o));

	// ***************************************************************
	// Clock, data memory and hang guard
	// ***************************************************************
	initial clk_i = 1'b0;
	always #4 clk_i = ~clk_i;

	// Asynchronous read keeps the memory within the two clocks (Q2 and Q3) the core allows for an answer
	assign mem_rdata_i = ram[mem_addr_o];

	// Every write pulse is counted so a stray or missing write shows up
	always @(posedge clk_i) begin
		if (mem_we_o === 1'b1) begin
			ram[mem_addr_o] <= mem_wdata_o;
			writes++;
		end
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	// ***************************************************************
	// Bus, compare and execution tasks
	// ***************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Classic single cycle; request held until ack is sampled, then released for a cycle
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		// No local limit: only the hang guard ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
		wb(1'b0, adr, 32'h0000_0000);
		chk(what, exp, r);
	endtask : rd

	// Issue one instruction, count busy clocks, then compare the program counter
	task automatic run(input logic [15:0] ins, input int exp_busy, input int exp_pc, input string what);
		int n;
		n = 0;
		wb(1'b1, bbs_pkg::REG_INSTR, {16'h0000, ins});
		while (busy_o === 1'b1 && n < 40) begin
			n++;
			@(posedge clk_i);
		end
		pc_m = exp_pc & 32'h001F_FFFF;
		chk({what, " clocks"}, exp_busy, n);
		chk({what, " pc port"}, pc_m, {11'h000, pc_o});
		rd(bbs_pkg::REG_PC, pc_m, {what, " pc reg"});
	endtask : run

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		rst_i    = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		for (int i = 0; i < 4096; i++) begin
			ram[i] = $random(seed);
		end
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(bbs_pkg::REG_PC, 32'h0000_0000, "pc after reset");
		rd(bbs_pkg::REG_STATUS, 32'h0000_0000, "status after reset");
		rd(8'h1C, 32'h0000_0000, "unmapped read");
		$display("TEST reset done");

		// Both edges of the offset range, taken and not taken, for each flag
		for (int k = 0; k < 3; k++) begin
			for (int t = 0; t < 4; t++) begin
				fl = $random(seed) & 7;
				if (t < 2) fl = fl & ~(1 << fbit[k]);
				if (t == 2) fl = fl | (1 << fbit[k]);
				off = (t == 0) ? 8'h80 : (t == 1) ? 8'h7F : $random(seed);
				wb(1'b1, bbs_pkg::REG_FLAGS, fl);
				if (((fl >> fbit[k]) & 1) == 0) begin
					run({ops[k], off}, 8, pc_m + 2 + 2 * $signed(off), "taken");
				end else begin
					run({ops[k], off}, 4, pc_m + 2, "not taken");
				end
			end
		end
		$display("TEST conditional branches done");

		// Start near the top so the largest forward jump wraps the counter
		pc_m = 32'h001F_FFF0;
		wb(1'b1, bbs_pkg::REG_PC, pc_m);
		for (int t = 0; t < 4; t++) begin
			off11 = (t == 0) ? 11'h3FF : (t == 1) ? 11'h400 : $random(seed);
			run({5'b11010, off11}, 8, pc_m + 2 + 2 * $signed(off11), "always");
		end
		$display("TEST unconditional branch done");

		// Every bit position, each addressing path and the indexed boundary at 95
		for (int i = 0; i < 8; i++) begin
			bank_m = $random(seed) & 15;
			index_m = $random(seed) & 32'h0000_0FFF;
			fl = $random(seed) & 7;
			wb(1'b1, bbs_pkg::REG_BANK, bank_m);
			wb(1'b1, bbs_pkg::REG_INDEX, index_m);
			wb(1'b1, bbs_pkg::REG_CTRL, ex[i]);
			wb(1'b1, bbs_pkg::REG_FLAGS, fl);
			if (av[i] == 1) addr = bank_m * 256 + fa[i];
			else if (ex[i] == 1 && fa[i] <= 95) addr = (index_m + fa[i]) & 32'h0000_0FFF;
			else if (fa[i] < 128) addr = fa[i];
			else addr = 32'h0000_0F00 + fa[i];
			ram[addr] = $random(seed) & ~(1 << i);
			w0 = ram[addr] | (1 << i);
			writes = 0;
			run({4'h8, i[2:0], av[i][0], fa[i][7:0]}, 4, pc_m + 2, "bit set");
			chk("bit set data", w0, {24'h00_0000, ram[addr]});
			chk("bit set writes", 1, writes);
			rd(bbs_pkg::REG_FLAGS, fl, "flags kept");
		end
		$display("TEST bit set done");

		// An undefined code only advances the counter and raises the sticky flag
		run(16'h0000, 4, pc_m + 2, "bad opcode");
		rd(bbs_pkg::REG_STATUS, 32'h0000_0002, "bad flag set");
		wb(1'b1, bbs_pkg::REG_STATUS, 32'h0000_0002);
		rd(bbs_pkg::REG_STATUS, 32'h0000_0000, "bad flag cleared");
		$display("TEST bad opcode done");

		// Writes to PC and INSTR while busy are acknowledged but ignored
		wb(1'b1, bbs_pkg::REG_INSTR, 32'h0000_D005);
		wb(1'b1, bbs_pkg::REG_PC, 32'h0000_0100);
		wb(1'b1, bbs_pkg::REG_INSTR, 32'h0000_0000);
		while (busy_o === 1'b1) begin
			@(posedge clk_i);
		end
		pc_m = (pc_m + 2 + 2 * 5) & 32'h001F_FFFF;
		rd(bbs_pkg::REG_PC, pc_m, "pc kept while busy");
		rd(bbs_pkg::REG_INSTR, 32'h0000_D005, "instr kept while busy");
		rd(bbs_pkg::REG_STATUS, 32'h0000_0000, "no second instruction");
		$display("TEST busy refusal done");

		// A reset in mid-instruction abandons it and restores every register
		wb(1'b1, bbs_pkg::REG_INSTR, 32'h0000_D005);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("busy after reset", 32'h0000_0000, {31'h0000_0000, busy_o});
		chk("pc port after reset", 32'h0000_0000, {11'h000, pc_o});
		rd(bbs_pkg::REG_PC, 32'h0000_0000, "pc reg after reset");
		rd(bbs_pkg::REG_FLAGS, 32'h0000_0000, "flags after reset");
		run(16'hD000, 8, 2, "after reset");
		$display("TEST mid-run reset done");
		summarize();
	end
endmodule : testbench

`default_nettype wire
